// *** src/memmap_defs.svh ***
`ifndef MEMMAP_DEFS_SVH
`define MEMMAP_DEFS_SVH

// ----------------------------------------
// program space
// ----------------------------------------
`define PC_RESET 23'h000000
`define PC_STEP 23'h000002
`define RESET_VEC_ADDR 24'h000000
`define RESET_TARGET_ADDR 24'h000002
`define PRIMARY_LO 24'h000004
`define PRIMARY_HI 24'h0000ff
`define ALTERNATE_LO 24'h000100
`define ALTERNATE_HI 24'h0001ff
`define USER_LO 24'h000200
`define FLASH_END 24'h015800
`define USER_TOP 24'h7fffff
`define CFG_BIT 23
`define PAGE_CFG_BIT 7
`define HI_UNUSED 8'h00

// ----------------------------------------
// data space
// ----------------------------------------
`define WINDOW_BIT 15
`define RAM_BYTES 16'h2000
`define RAM_WORDS 4096
`define RAM_AW 12

`endif

// *** src/memmap_pkg.sv ***
// ----------------------------------------
// shared types
// ----------------------------------------
package memmap_pkg;

  typedef enum logic [5:0] {
    region_reset_vec = 6'h01,
    region_primary = 6'h02,
    region_alternate = 6'h04,
    region_user = 6'h08,
    region_unimpl = 6'h10,
    region_config = 6'h20
  } prog_region_e;

  typedef struct packed {
    logic valid;
    logic byte_op;
    logic [15:0] ea;
  } data_rd_s;

  typedef struct packed {
    logic valid;
    logic byte_op;
    logic [15:0] ea;
    logic [15:0] wdata;
  } data_wr_s;

  typedef struct packed {
    logic valid;
    logic [7:0] page;
    logic [15:0] offset;
  } table_rd_s;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } prog_pair_s;

endpackage : memmap_pkg

// *** src/prog_space_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defs.svh"

module prog_space_decoder (
  input wire logic [23:0] prog_addr,
  input wire logic cfg_access,
  input wire memmap_pkg::prog_pair_s pair,
  output memmap_pkg::prog_region_e region,
  output logic [23:0] word
);

  // ----------------------------------------
  // region classify and zero fill
  // ----------------------------------------
  always_comb begin
    if (prog_addr[`CFG_BIT]) begin
      region = memmap_pkg::region_config;
    end else if (prog_addr < `PRIMARY_LO) begin
      region = memmap_pkg::region_reset_vec;
    end else if (prog_addr <= `PRIMARY_HI) begin
      region = memmap_pkg::region_primary;
    end else if (prog_addr <= `ALTERNATE_HI) begin
      region = memmap_pkg::region_alternate;
    end else if (prog_addr < `FLASH_END) begin
      region = memmap_pkg::region_user;
    end else begin
      region = memmap_pkg::region_unimpl;
    end
  end

  always_comb begin
    if ((prog_addr[`CFG_BIT] && !cfg_access) ||
        (region == memmap_pkg::region_unimpl)) begin
      word = 24'h000000;
    end else begin
      word = {pair.hi[7:0], pair.lo};
    end
  end

endmodule : prog_space_decoder
`default_nettype wire

// *** src/data_space_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defs.svh"

module data_space_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire memmap_pkg::data_rd_s rd,
  input wire memmap_pkg::data_wr_s wr,
  input wire logic [15:0] window_word,
  output logic rd_ack_r,
  output logic [15:0] rd_data_r,
  output logic addr_err_r
);

  logic [15:0] mem [0:`RAM_WORDS-1];
  logic rd_in_ram;
  logic wr_in_ram;
  logic [15:0] rd_word;
  logic [15:0] rd_data_nxt;
  logic [`RAM_AW-1:0] wr_idx;
  logic [15:0] wr_merged;
  logic [1:0] lane_we;

  // ----------------------------------------
  // read side
  // ----------------------------------------
  assign rd_in_ram = !rd.ea[`WINDOW_BIT] && (rd.ea < `RAM_BYTES);
  assign wr_in_ram = !wr.ea[`WINDOW_BIT] && (wr.ea < `RAM_BYTES);

  always_comb begin
    if (rd.ea[`WINDOW_BIT]) begin
      rd_word = window_word;
    end else if (rd_in_ram) begin
      rd_word = mem[rd.ea[`RAM_AW:1]];
    end else begin
      rd_word = 16'h0000;
    end
    if (!rd.byte_op) begin
      rd_data_nxt = rd_word;
    end else if (rd.ea[0]) begin
      rd_data_nxt = {8'h00, rd_word[15:8]};
    end else begin
      rd_data_nxt = {8'h00, rd_word[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ack_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      rd_ack_r <= rd.valid;
      if (rd.valid) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  // ----------------------------------------
  // write side, per byte lane
  // ----------------------------------------
  assign wr_idx = wr.ea[`RAM_AW:1];

  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign lane_we[i] = wr.valid && wr_in_ram &&
      (wr.byte_op ? (wr.ea[0] == 1'(i)) : !wr.ea[0]);
    assign wr_merged[8*i +: 8] = !lane_we[i] ? mem[wr_idx][8*i +: 8] :
      (wr.byte_op ? wr.wdata[7:0] : wr.wdata[8*i +: 8]);
  end

  always_ff @(posedge clk) begin
    if (|lane_we) begin
      mem[wr_idx] <= wr_merged;
    end
  end

  // ----------------------------------------
  // misaligned word trap
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_err_r <= 1'b0;
    end else begin
      addr_err_r <= (rd.valid && !rd.byte_op && rd.ea[0]) ||
        (wr.valid && !wr.byte_op && wr.ea[0]);
    end
  end

  ram_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd.valid && !rd.ea[`WINDOW_BIT] && rd.ea >= `RAM_BYTES |=> rd_data_r == 16'h0000)
    else $error("read beyond ram not zero");

  write_drop_a: assert property (@(posedge clk) disable iff (rst)
    wr.valid && !wr.byte_op && wr.ea[0] |=> mem[$past(wr_idx)] == $past(mem[wr_idx]))
    else $error("misaligned word write stored");

endmodule : data_space_decoder
`default_nettype wire

// *** src/memory_address_map_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "memmap_defs.svh"

module memory_address_map_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_en,
  input wire logic fetch_down,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_addr,
  output logic fetch_stall,
  output logic fetch_valid_r,
  output logic [23:0] fetch_addr_r,
  output logic [23:0] fetch_word_r,
  output memmap_pkg::prog_region_e fetch_region_r,
  input wire memmap_pkg::table_rd_s tbl,
  output logic tbl_busy,
  output logic tbl_ack_r,
  output logic [15:0] tbl_data_r,
  input wire memmap_pkg::data_rd_s data_rd,
  input wire memmap_pkg::data_wr_s data_wr,
  input wire logic window_en,
  input wire logic [7:0] window_page,
  output logic rd_ack_r,
  output logic [15:0] rd_data_r,
  output logic addr_error_r,
  output logic [23:0] prog_mem_addr,
  input wire memmap_pkg::prog_pair_s prog_mem_data
);

  logic [22:0] pc_r;
  logic win_go;
  logic tbl_go;
  logic fetch_go;
  logic cfg_access;
  logic [23:0] pc_addr;
  logic [23:0] win_addr;
  logic [23:0] tbl_addr;
  logic [15:0] window_word;
  logic [23:0] word;
  memmap_pkg::prog_region_e region;
  logic virgin_r;

  // ----------------------------------------
  // program port arbitration
  // ----------------------------------------
  assign win_go = data_rd.valid && data_rd.ea[`WINDOW_BIT];
  assign tbl_busy = win_go;
  assign tbl_go = tbl.valid && !win_go;
  assign fetch_stall = win_go || tbl.valid;
  assign fetch_go = fetch_en && !fetch_stall && !pc_load;
  assign cfg_access = tbl_go && tbl.page[`PAGE_CFG_BIT];

  assign pc_addr = {1'b0, pc_r};
  assign win_addr = {1'b0, window_page, data_rd.ea[14:1], 1'b0};
  assign tbl_addr = {tbl.page, tbl.offset[15:1], 1'b0};

  always_comb begin
    if (win_go) begin
      prog_mem_addr = win_addr;
    end else if (tbl.valid) begin
      prog_mem_addr = tbl_addr;
    end else begin
      prog_mem_addr = pc_addr;
    end
  end

  prog_space_decoder u_prog (
    .prog_addr(prog_mem_addr),
    .cfg_access(cfg_access),
    .pair(prog_mem_data),
    .region(region),
    .word(word)
  );

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_r <= `PC_RESET;
    end else if (pc_load) begin
      pc_r <= {pc_load_addr[22:1], 1'b0};
    end else if (fetch_go) begin
      pc_r <= fetch_down ? pc_r - `PC_STEP : pc_r + `PC_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      virgin_r <= 1'b1;
    end else if (fetch_go || pc_load) begin
      virgin_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // fetch result
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_valid_r <= 1'b0;
      fetch_addr_r <= `RESET_VEC_ADDR;
      fetch_word_r <= 24'h000000;
      fetch_region_r <= memmap_pkg::region_reset_vec;
    end else begin
      fetch_valid_r <= fetch_go;
      if (fetch_go) begin
        fetch_addr_r <= pc_addr;
        fetch_word_r <= word;
        fetch_region_r <= region;
      end
    end
  end

  // ----------------------------------------
  // table read result
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_ack_r <= 1'b0;
      tbl_data_r <= 16'h0000;
    end else begin
      tbl_ack_r <= tbl_go;
      if (tbl_go) begin
        tbl_data_r <= tbl.offset[0] ?
          {`HI_UNUSED, word[23:16]} : word[15:0];
      end
    end
  end

  // ----------------------------------------
  // data space
  // ----------------------------------------
  assign window_word = window_en ? word[15:0] : 16'h0000;

  data_space_decoder u_data (
    .clk(clk),
    .rst(rst),
    .rd(data_rd),
    .wr(data_wr),
    .window_word(window_word),
    .rd_ack_r(rd_ack_r),
    .rd_data_r(rd_data_r),
    .addr_err_r(addr_error_r)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence first_fetch_s;
    fetch_go && virgin_r && !fetch_down;
  endsequence

  sequence rd_taken_s;
    data_rd.valid ##1 rd_ack_r;
  endsequence

  reset_fetch_a: assert property (
    fetch_go && virgin_r |-> prog_mem_addr == `RESET_VEC_ADDR)
    else $error("first fetch not at zero");

  reset_pair_a: assert property (
    first_fetch_s |=> pc_addr == `RESET_TARGET_ADDR)
    else $error("second fetch not at start address slot");

  pc_up_a: assert property (
    fetch_go && !fetch_down |=> pc_r == $past(pc_r) + `PC_STEP)
    else $error("counter did not step up by two");

  pc_down_a: assert property (
    fetch_go && fetch_down |=> pc_r == $past(pc_r) - `PC_STEP)
    else $error("counter did not step down by two");

  pc_even_a: assert property (
    pc_load |=> !pc_r[0] ##1 !pc_r[0])
    else $error("counter left even alignment");

  word_pack_a: assert property (
    fetch_go && region == memmap_pkg::region_user |=>
      fetch_word_r == {$past(prog_mem_data.hi[7:0]), $past(prog_mem_data.lo)})
    else $error("fetched word not packed from two words");

  unimpl_zero_a: assert property (
    fetch_go && pc_addr >= `FLASH_END |=>
      fetch_valid_r && fetch_word_r == 24'h000000 &&
      fetch_region_r == memmap_pkg::region_unimpl)
    else $error("unimplemented program read not zero");

  vector_space_a: assert property (
    fetch_valid_r && fetch_addr_r < `USER_LO |->
      fetch_region_r != memmap_pkg::region_user)
    else $error("vector space taken as user code");

  primary_table_a: assert property (
    fetch_valid_r && fetch_addr_r >= `PRIMARY_LO &&
      fetch_addr_r <= `PRIMARY_HI |->
      fetch_region_r == memmap_pkg::region_primary)
    else $error("primary vector range misclassified");

  alternate_table_a: assert property (
    fetch_valid_r && fetch_addr_r >= `ALTERNATE_LO &&
      fetch_addr_r <= `ALTERNATE_HI |->
      fetch_region_r == memmap_pkg::region_alternate)
    else $error("alternate vector range misclassified");

  table_upper_a: assert property (
    tbl_go && tbl.offset[0] && tbl_addr < `FLASH_END |=>
      tbl_data_r == {`HI_UNUSED, $past(prog_mem_data.hi[7:0])})
    else $error("odd table read not upper word");

  table_config_a: assert property (
    tbl_go && tbl.page[`PAGE_CFG_BIT] && !tbl.offset[0] |=>
      tbl_data_r == $past(prog_mem_data.lo))
    else $error("table read into config space blocked");

  window_config_a: assert property (
    win_go && window_page[`PAGE_CFG_BIT] |=> rd_data_r == 16'h0000)
    else $error("window reached config space");

  window_route_a: assert property (
    win_go && window_en && !data_rd.byte_op && win_addr < `FLASH_END |=>
      rd_data_r == $past(prog_mem_data.lo))
    else $error("window read not routed to program space");

  rd_answer_a: assert property (
    data_rd.valid && data_wr.valid |-> rd_taken_s)
    else $error("read not answered beside a write");

  byte_odd_a: assert property (
    data_rd.valid && data_rd.byte_op |=> rd_data_r[15:8] == 8'h00)
    else $error("byte read high bits not clear");

  odd_trap_a: assert property (
    data_rd.valid && !data_rd.byte_op && data_rd.ea[0] |=>
      addr_error_r && rd_ack_r ##1 !addr_error_r || $past(data_rd.valid))
    else $error("misaligned word read did not trap");

  user_top_a: assert property (
    fetch_go |-> pc_addr <= `USER_TOP)
    else $error("fetch above user space");

  window_first_a: assert property (
    win_go |-> fetch_stall && tbl_busy && prog_mem_addr == win_addr)
    else $error("window read lost the program port");

  table_next_a: assert property (
    tbl.valid && !win_go |-> fetch_stall && prog_mem_addr == tbl_addr)
    else $error("table read lost the program port");

  load_wins_a: assert property (
    pc_load |=> pc_r == {$past(pc_load_addr[22:1]), 1'b0} && !fetch_valid_r)
    else $error("counter load not taken over fetch");

  fetch_even_a: assert property (
    fetch_valid_r |-> !fetch_addr_r[0])
    else $error("fetch address not on lower word");

  fetch_addr_a: assert property (
    fetch_go |=> fetch_valid_r && fetch_addr_r == $past(pc_addr))
    else $error("fetch address not taken from counter");

  table_zero_a: assert property (
    tbl_go && !tbl.page[`PAGE_CFG_BIT] && tbl_addr >= `FLASH_END |=>
      tbl_ack_r && tbl_data_r == 16'h0000)
    else $error("table read beyond flash not zero");

  window_off_a: assert property (
    win_go && !window_en |=> rd_ack_r && rd_data_r == 16'h0000)
    else $error("disabled window read not zero");

  fetch_cfg_a: assert property (
    fetch_valid_r |-> fetch_region_r != memmap_pkg::region_config)
    else $error("fetch reached config space");

endmodule : memory_address_map_decoder
`default_nettype wire

// *** test/prog_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// program memory
// ----------------------------------------
module prog_mem_model (
  input wire logic [23:0] addr,
  output var memmap_pkg::prog_pair_s data
);
  // low word of the even address, high word of the odd one
  assign data.lo = addr[16:1] ^ {addr[23:20], 12'h5a5};
  // top byte of the high word holds junk the block must drop
  assign data.hi = {8'hee, addr[8:1] ^ 8'hc3};
endmodule : prog_mem_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0;
  logic rst = 1;
  logic fetch_en = 0;
  logic fetch_down = 0;
  logic pc_load = 0;
  logic [22:0] pc_load_addr = '0;
  memmap_pkg::table_rd_s tbl = '0;
  memmap_pkg::data_rd_s data_rd = '0;
  memmap_pkg::data_wr_s data_wr = '0;
  logic window_en = 0;
  logic [7:0] window_page = '0;
  logic fetch_valid_r, tbl_ack_r, rd_ack_r, addr_error_r, fetch_stall, tbl_busy;
  logic [23:0] fetch_addr_r, fetch_word_r, prog_mem_addr;
  memmap_pkg::prog_region_e fetch_region_r;
  logic [15:0] tbl_data_r, rd_data_r;
  memmap_pkg::prog_pair_s prog_mem_data;
  logic [53:0] fq[$];
  logic [15:0] tq[$];
  logic [17:0] dq[$];
  logic [15:0] ram [0:4095];
  logic [23:0] tv [6] = '{24'h000002, 24'h000101, 24'h015800, 24'h0157ff,
    24'h800000, 24'h800005};
  int n_mismatch = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  memory_address_map_decoder i_dut (.clk(clk), .rst(rst), .fetch_en(fetch_en),
    .fetch_down(fetch_down), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .fetch_stall(fetch_stall), .fetch_valid_r(fetch_valid_r), .fetch_addr_r(fetch_addr_r),
    .fetch_word_r(fetch_word_r), .fetch_region_r(fetch_region_r), .tbl(tbl),
    .tbl_busy(tbl_busy), .tbl_ack_r(tbl_ack_r), .tbl_data_r(tbl_data_r), .data_rd(data_rd),
    .data_wr(data_wr), .window_en(window_en), .window_page(window_page),
    .rd_ack_r(rd_ack_r), .rd_data_r(rd_data_r), .addr_error_r(addr_error_r),
    .prog_mem_addr(prog_mem_addr), .prog_mem_data(prog_mem_data));

  prog_mem_model i_pm (.addr(prog_mem_addr), .data(prog_mem_data));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] pm(logic [23:0] a);
    return {8'hee, a[8:1] ^ 8'hc3, a[16:1] ^ {a[23:20], 12'h5a5}};
  endfunction : pm

  function automatic logic [5:0] rg(logic [23:0] a);
    return a < 24'h4 ? 6'h01 : a < 24'h100 ? 6'h02 : a < 24'h200 ? 6'h04 :
      a < 24'h15800 ? 6'h08 : 6'h10;
  endfunction : rg

  task automatic chk(logic [63:0] got, logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_fetch(logic [53:0] g, logic [53:0] e);
    chk(64'(g), 64'(e));
  endtask : chk_fetch

  task automatic chk_tbl(logic [15:0] g, logic [15:0] e);
    chk(64'(g), 64'(e));
  endtask : chk_tbl

  task automatic chk_data(logic [17:0] g, logic [17:0] e);
    chk(64'(g), 64'(e));
  endtask : chk_data

  task automatic chk_port(logic [1:0] g, logic [1:0] e);
    chk(64'(g), 64'(e));
  endtask : chk_port

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(negedge clk) begin
    if (!rst) begin
      if (fetch_valid_r === 1'b1)
        chk_fetch({fetch_addr_r, fetch_word_r, fetch_region_r}, fq.pop_front());
      if (tbl_ack_r === 1'b1)
        chk_tbl(tbl_data_r, tq.pop_front());
      if ((rd_ack_r | addr_error_r) === 1'b1)
        chk_data({addr_error_r, rd_ack_r, rd_ack_r ? rd_data_r : 16'h0}, dq.pop_front());
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic idle();
    tbl <= '0;
    data_rd <= '0;
    data_wr <= '0;
    @(negedge clk);
  endtask : idle

  task automatic fetch_run(logic [22:0] st, logic dn, logic ld, int n);
    logic [23:0] a;
    logic [31:0] p;
    if (ld) begin
      pc_load <= 1'b1;
      pc_load_addr <= st;
      @(negedge clk);
      pc_load <= 1'b0;
    end
    fetch_en <= 1'b1;
    fetch_down <= dn;
    a = {1'b0, st};
    repeat (n) begin
      p = pm(a);
      fq.push_back({a, a < 24'h15800 ? p[23:0] : 24'h0, rg(a)});
      @(negedge clk);
      a = dn ? a - 24'h2 : a + 24'h2;
    end
    fetch_en <= 1'b0;
  endtask : fetch_run

  task automatic tbl_rd(logic [7:0] pg, logic [15:0] off);
    logic [23:0] a;
    logic [31:0] p;
    a = {pg, off[15:1], 1'b0};
    p = pm(a);
    tbl <= {1'b1, pg, off};
    tq.push_back(!pg[7] && a >= 24'h15800 ? 16'h0 : off[0] ? {8'h00, p[23:16]} : p[15:0]);
    @(negedge clk);
  endtask : tbl_rd

  task automatic rd(logic [15:0] ea, logic b);
    logic [15:0] w;
    logic [15:0] e;
    logic [23:0] a;
    logic [31:0] p;
    a = {1'b0, window_page, ea[14:1], 1'b0};
    p = pm(a);
    if (ea[15])
      w = (!window_en || window_page[7] || a >= 24'h15800) ? 16'h0 : p[15:0];
    else if (ea >= 16'h2000)
      w = 16'h0;
    else
      w = ram[ea[12:1]];
    e = !b ? w : ea[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    data_wr <= '0;
    data_rd <= {1'b1, b, ea};
    dq.push_back({!b & ea[0], 1'b1, e});
    @(negedge clk);
  endtask : rd

  task automatic wr(logic [15:0] ea, logic b, logic [15:0] d);
    data_rd <= '0;
    data_wr <= {1'b1, b, ea, d};
    if (!b && ea[0])
      dq.push_back({2'b10, 16'h0});
    else if (ea < 16'h2000) begin
      if (!b)
        ram[ea[12:1]] = d;
      else if (ea[0])
        ram[ea[12:1]][15:8] = d[7:0];
      else
        ram[ea[12:1]][7:0] = d[7:0];
    end
    @(negedge clk);
  endtask : wr

  task automatic clash(logic [15:0] d);
    logic [31:0] p;
    logic [31:0] q;
    p = pm(24'h000040);
    q = pm(24'h000300);
    data_rd <= '0;
    window_en <= 1'b1;
    window_page <= 8'h00;
    pc_load <= 1'b1;
    pc_load_addr <= 23'h000300;
    @(negedge clk);
    pc_load <= 1'b0;
    fetch_en <= 1'b1;
    fetch_down <= 1'b0;
    tbl <= {1'b1, 8'h00, 16'h0301};
    data_rd <= {1'b1, 1'b0, 16'h8040};
    data_wr <= {1'b1, 1'b0, 16'h0040, d};
    ram[12'h020] = d;
    dq.push_back({2'b01, p[15:0]});
    tq.push_back({8'h00, q[23:16]});
    fq.push_back({24'h000300, q[23:0], 6'h08});
    @(negedge clk);
    chk_port({fetch_stall, tbl_busy}, 2'b11);
    data_rd <= '0;
    data_wr <= '0;
    @(negedge clk);
    chk_port({fetch_stall, tbl_busy}, 2'b10);
    tbl <= '0;
    @(negedge clk);
    chk_port({fetch_stall, tbl_busy}, 2'b00);
    fetch_en <= 1'b0;
  endtask : clash

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic print_verdict();
    chk(64'(fq.size() + tq.size() + dq.size()), 64'h0);
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h659f3c15));
    repeat (20) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    fetch_run(23'h0, 1'b0, 1'b0, 3);
    fetch_run(23'h0000fc, 1'b0, 1'b1, 3);
    fetch_run(23'h0001fc, 1'b0, 1'b1, 3);
    fetch_run(23'h000204, 1'b1, 1'b1, 3);
    fetch_run(23'h000004, 1'b1, 1'b1, 3);
    fetch_run(23'h0157fc, 1'b0, 1'b1, 3);
    fetch_run(23'h7ffffe, 1'b0, 1'b1, 1);
    foreach (tv[i]) tbl_rd(tv[i][23:16], tv[i][15:0]);
    idle();
    for (int i = 0; i < 4096; i++) wr(16'(i * 2), 1'b0, 16'($urandom));
    wr(16'h0101, 1'b1, 16'($urandom));
    wr(16'h0100, 1'b1, 16'($urandom));
    rd(16'h0100, 1'b0);
    rd(16'h0101, 1'b1);
    wr(16'h0203, 1'b0, 16'h1234);
    rd(16'h0202, 1'b0);
    rd(16'h0203, 1'b0);
    wr(16'h8010, 1'b0, 16'h4321);
    wr(16'h2010, 1'b0, 16'h4321);
    rd(16'h0010, 1'b0);
    rd(16'h2010, 1'b0);
    clash(16'($urandom));
    rd(16'h0040, 1'b0);
    for (int k = 0; k < 4; k++) begin
      window_en <= (k != 0);
      window_page <= (k == 3) ? 8'h80 : 8'(k);
      idle();
      repeat (60) rd(16'($urandom), 1'($urandom));
    end
    idle();
    repeat (3) @(negedge clk);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
